// ===== opv_program_unit.sv
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`include "opv_defs.svh"
module opv_program_unit #(
   parameter int WRITE_CYCLES = `OPV_WRITE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic vpp_present,
   output logic core_hold,
   output logic sys_reset_req,
   output logic prog_mode
);
   import opv_pkg::*;

   logic vpp_s1_q;
   logic vpp_s2_q;
   logic vpp_s3_q;
   logic vpp_ok_q;
   logic [7:0] dev_ctl_q;
   logic [7:0] mem_ctl_q;
   logic reset_pulse_q;
   opv_mode_t mode_q;
   opv_mode_t mode_d;
   logic [15:0] addr_q;
   logic [15:0] wr_cnt_q;
   logic err_q;
   logic [7:0] rdata_q;

   wire wr_dev_control = reg_wr && (reg_addr == `OPV_REG_DEV_CONTROL);
   wire wr_memctl = reg_wr && (reg_addr == `OPV_REG_MEMCTL);
   wire wr_addrh = reg_wr && (reg_addr == `OPV_REG_ADDRH);
   wire wr_addrl = reg_wr && (reg_addr == `OPV_REG_ADDRL);
   wire wr_data = reg_wr && (reg_addr == `OPV_REG_DATA);
   wire wr_sum_block = reg_wr && (reg_addr == `OPV_REG_SUM_B0);
   wire wr_sum_full = reg_wr && (reg_addr == `OPV_REG_SUM_B1);

   wire [7:0] sec_byte;
   wire [7:0] mem_rd_data;
   wire [15:0] crc_addr;
   opv_crc_req_t crc_req;
   opv_crc_rsp_t crc_rsp;

   wire write_busy = (wr_cnt_q != 16'h0000);
   wire any_busy = write_busy || crc_rsp.busy;
   wire in_prog = (mode_q == OPV_MODE_PROG);
   wire write_locked = ~&sec_byte[7:4];
   wire read_locked = ~&sec_byte[3:0];
   wire out_of_range = (addr_q[15:13] != 3'b000);
   wire reserved_hit = (addr_q >= `OPV_RESERVED_LO) && (addr_q != `OPV_SEC_ADDR) && !out_of_range;
   // Writes arriving mid-cycle are dropped rather than queued
   wire accept = wr_data && in_prog && !any_busy;
   wire fail = write_locked || reserved_hit || out_of_range || !vpp_ok_q;
   wire mem_we = accept && !fail;
   wire is_sec = (addr_q == `OPV_SEC_ADDR);
   wire read_ok = !out_of_range && (is_sec || !read_locked);

   // CRC ignores the locks, it never exposes raw bytes
   assign crc_req.start = (wr_sum_block || wr_sum_full) && !any_busy;
   assign crc_req.wide = wr_sum_full;
   assign crc_req.base = reg_wdata;

   wire [12:0] mem_rd_addr = crc_rsp.busy ? crc_addr[12:0] : addr_q[12:0];
   wire [7:0] data_view = (read_ok && !crc_rsp.busy) ? mem_rd_data : 8'h00;
   wire [7:0] status_view = (any_busy ? `OPV_STAT_BUSY_MASK : 8'h00) | (err_q ? `OPV_STAT_ERR_MASK : 8'h00);
   wire [7:0] rd_mux =
      (reg_addr == `OPV_REG_DEV_CONTROL) ? dev_ctl_q :
      (reg_addr == `OPV_REG_MEMCTL) ? mem_ctl_q :
      (reg_addr == `OPV_REG_ADDRH) ? addr_q[15:8] :
      (reg_addr == `OPV_REG_ADDRL) ? addr_q[7:0] :
      (reg_addr == `OPV_REG_DATA) ? data_view :
      (reg_addr == `OPV_REG_SUM_B0) ? crc_rsp.result[7:0] :
      (reg_addr == `OPV_REG_SUM_B1) ? crc_rsp.result[15:8] :
      (reg_addr == `OPV_REG_SUM_B2) ? crc_rsp.result[23:16] :
      (reg_addr == `OPV_REG_SUM_B3) ? crc_rsp.result[31:24] :
      (reg_addr == `OPV_REG_STATUS) ? status_view : 8'h00;

   // Two-step entry; exit by STEP1 then OFF, or by OFF alone; a stray value while armed drops back to the off state
   always_comb begin
      mode_d = mode_q;
      if (wr_memctl) begin
         unique case (mode_q)
            OPV_MODE_OFF: begin
               mode_d = (reg_wdata == `OPV_MEMCTL_STEP1) ? OPV_MODE_ARMED : OPV_MODE_OFF;
            end
            OPV_MODE_ARMED: begin
               if (reg_wdata == `OPV_MEMCTL_STEP2) begin
                  mode_d = OPV_MODE_PROG;
               end else if (reg_wdata != `OPV_MEMCTL_STEP1) begin
                  mode_d = OPV_MODE_OFF;
               end
            end
            OPV_MODE_PROG: begin
               if (reg_wdata == `OPV_MEMCTL_STEP1) begin
                  mode_d = OPV_MODE_LEAVE;
               end else if (reg_wdata == `OPV_MEMCTL_OFF) begin
                  mode_d = OPV_MODE_OFF;
               end
            end
            OPV_MODE_LEAVE: begin
               if (reg_wdata == `OPV_MEMCTL_OFF) begin
                  mode_d = OPV_MODE_OFF;
               end
            end
         endcase
      end
   end

   // Pin filter: change taken once stages two and three agree
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         vpp_s1_q <= 1'b0;
         vpp_s2_q <= 1'b0;
         vpp_s3_q <= 1'b0;
         vpp_ok_q <= 1'b0;
      end else begin
         vpp_s1_q <= vpp_present;
         vpp_s2_q <= vpp_s1_q;
         vpp_s3_q <= vpp_s2_q;
         if (vpp_s2_q == vpp_s3_q) begin
            vpp_ok_q <= vpp_s3_q;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dev_ctl_q <= 8'h00;
         reset_pulse_q <= 1'b0;
      end else begin
         reset_pulse_q <= wr_dev_control && reg_wdata[`OPV_DEV_RESET_BIT];
         if (wr_dev_control) begin
            dev_ctl_q <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= OPV_MODE_OFF;
         mem_ctl_q <= 8'h00;
      end else begin
         mode_q <= mode_d;
         if (wr_memctl) begin
            mem_ctl_q <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         addr_q <= 16'h0000;
      end else if (wr_addrh) begin
         addr_q <= {reg_wdata, addr_q[7:0]};
      end else if (wr_addrl) begin
         addr_q <= {addr_q[15:8], reg_wdata};
      end else if (accept) begin
         addr_q <= addr_q + 16'h0001;
      end
   end

   // Failed bytes still take the full cycle, so polling stays uniform
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_cnt_q <= 16'h0000;
      end else if (accept) begin
         wr_cnt_q <= 16'(WRITE_CYCLES);
      end else if (write_busy) begin
         wr_cnt_q <= wr_cnt_q - 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         err_q <= 1'b0;
      end else if (accept) begin
         err_q <= fail;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         rdata_q <= rd_mux;
      end
   end

   opv_otp_array u_array (
      .clk_sys(clk_sys),
      .wr_en(mem_we),
      .wr_addr(addr_q[12:0]),
      .wr_data(reg_wdata),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rd_data),
      .sec_byte(sec_byte)
   );

   opv_crc_engine u_crc (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .req(crc_req),
      .mem_data(mem_rd_data),
      .mem_addr(crc_addr),
      .rsp(crc_rsp)
   );

   assign reg_rdata = rdata_q;
   assign core_hold = dev_ctl_q[`OPV_DEV_HOLD_BIT];
   assign sys_reset_req = reset_pulse_q;
   assign prog_mode = in_prog;
endmodule : opv_program_unit

// ===== opv_defs.svh
`ifndef OPV_DEFS_SVH
`define OPV_DEFS_SVH
// Behaviour
// - Locations 0x1E00 to 0x1FFF hold no user code; data writes there fail, except at 0x1FFF.
// - Each accepted data byte write advances the 16-bit address by one.
// - Programmer polls busy by status read; failed byte write sets the error flag.
// - Busy stays high for the byte write cycle time of 100 us.
// - Protection settings come from the security byte at location 0x1FFF.
// - The security byte is always readable whatever the locks.
// - Any zero in security bits 7 to 4 blocks every code memory write.
// - Any zero in security bits 3 to 0 blocks every code memory read.
// - Locks cannot be undone; programmer sets write lock only after all code.
// - CRC runs even when memory is fully read and write locked.
// - Block CRC covers exactly one 256-byte block starting at low byte 0x00.
// - Write to checksum byte 1 starts a 32-bit CRC from 0x0000 to user end.
// - The 32-bit CRC uses polynomial 0x04C11DB7.
// - Busy is high while any CRC runs and drops when it completes.
// - Write to checksum byte 0 starts a 16-bit CRC, polynomial 0x1021, on that block.

`define OPV_REG_DEV_CONTROL 8'h00
`define OPV_REG_MEMCTL 8'h01
`define OPV_REG_ADDRH 8'h02
`define OPV_REG_ADDRL 8'h03
`define OPV_REG_DATA 8'h04
`define OPV_REG_SUM_B0 8'h05
`define OPV_REG_SUM_B1 8'h06
`define OPV_REG_SUM_B2 8'h07
`define OPV_REG_SUM_B3 8'h08
`define OPV_REG_STATUS 8'h09

`define OPV_DEV_HOLD_BIT 2
`define OPV_DEV_RESET_BIT 1
`define OPV_MEMCTL_STEP1 8'h40
`define OPV_MEMCTL_STEP2 8'h58
`define OPV_MEMCTL_OFF 8'h00
`define OPV_STAT_BUSY_MASK 8'h80
`define OPV_STAT_ERR_MASK 8'h40

`define OPV_RESERVED_LO 16'h1e00
`define OPV_SEC_ADDR 16'h1fff
`define OPV_SEC_IDX 13'h1fff
`define OPV_USER_END 16'h1dff
`define OPV_ERASED 8'hff

`define OPV_POLY16 16'h1021
`define OPV_POLY32 32'h04c11db7
`define OPV_CRC_INIT 32'h00000000

`define OPV_CLK_MHZ 100
`define OPV_WRITE_TIME_US 100
`define OPV_WRITE_CYCLES (`OPV_WRITE_TIME_US * `OPV_CLK_MHZ)
`endif

// ===== opv_pkg.sv
package opv_pkg;
   typedef enum logic [1:0] {
      OPV_MODE_OFF = 2'b00,
      OPV_MODE_ARMED = 2'b01,
      OPV_MODE_PROG = 2'b10,
      OPV_MODE_LEAVE = 2'b11
   } opv_mode_t;

   typedef struct packed {
      logic start;
      logic wide;
      logic [7:0] base;
   } opv_crc_req_t;

   typedef struct packed {
      logic busy;
      logic [31:0] result;
   } opv_crc_rsp_t;
endpackage : opv_pkg

// ===== opv_otp_array.sv
`timescale 1ns/1ps
`include "opv_defs.svh"
module opv_otp_array (
   input wire logic clk_sys,
   input wire logic wr_en,
   input wire logic [12:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [12:0] rd_addr,
   output logic [7:0] rd_data,
   output logic [7:0] sec_byte
);
   import opv_pkg::*;
   logic [7:0] mem [0:8191];
   integer i;

   // Blank part reads erased
   initial begin
      for (i = 0; i < 8192; i = i + 1) begin
         mem[i] = `OPV_ERASED;
      end
   end

   // Programming only clears bits, so nothing written can be restored
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= mem[wr_addr] & wr_data;
      end
   end

   assign rd_data = mem[rd_addr];
   assign sec_byte = mem[`OPV_SEC_IDX];
endmodule : opv_otp_array

// ===== opv_crc_engine.sv
`timescale 1ns/1ps
`include "opv_defs.svh"
module opv_crc_engine (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire opv_pkg::opv_crc_req_t req,
   input wire logic [7:0] mem_data,
   output logic [15:0] mem_addr,
   output opv_pkg::opv_crc_rsp_t rsp
);
   import opv_pkg::*;
   logic busy_q;
   logic wide_q;
   logic [15:0] addr_q;
   logic [15:0] last_q;
   logic [31:0] crc_q;
   logic [15:0] first_d;
   logic [15:0] last_d;

   // MSB-first, one byte per clock
   function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [7:0] d, input logic wide);
      logic [31:0] c;
      logic fb;
      integer k;
      c = crc;
      for (k = 7; k >= 0; k = k - 1) begin
         if (wide) begin
            fb = c[31] ^ d[k];
            c = {c[30:0], 1'b0} ^ (fb ? `OPV_POLY32 : 32'h00000000);
         end else begin
            fb = c[15] ^ d[k];
            c = {16'h0000, c[14:0], 1'b0} ^ (fb ? {16'h0000, `OPV_POLY16} : 32'h00000000);
         end
      end
      crc_step = c;
   endfunction : crc_step

   // Only whole aligned blocks or the full user space can be chosen
   assign first_d = req.wide ? 16'h0000 : {req.base, 8'h00};
   assign last_d = req.wide ? `OPV_USER_END : {req.base, 8'hff};

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         wide_q <= 1'b0;
         addr_q <= 16'h0000;
         last_q <= 16'h0000;
         crc_q <= 32'h00000000;
      end else if (!busy_q) begin
         if (req.start) begin
            busy_q <= 1'b1;
            wide_q <= req.wide;
            addr_q <= first_d;
            last_q <= last_d;
            crc_q <= `OPV_CRC_INIT;
         end
      end else begin
         crc_q <= crc_step(crc_q, mem_data, wide_q);
         if (addr_q == last_q) begin
            busy_q <= 1'b0;
         end else begin
            addr_q <= addr_q + 16'h0001;
         end
      end
   end

   assign mem_addr = addr_q;
   assign rsp.busy = busy_q;
   assign rsp.result = crc_q;
endmodule : opv_crc_engine

// ===== opv_vpp_model.sv
`timescale 1ns/1ps
module opv_vpp_model (
   input wire logic apply,
   input wire logic prog_mode,
   output logic vpp_present
);
   initial vpp_present = 1'b0;
   // Supply comes up only after mode entry, with a slow ramp
   // and is pulled before the final mode write
   always @(apply or prog_mode) begin
      if (apply && prog_mode) vpp_present <= #40 1'b1;
      else vpp_present <= #25 1'b0;
   end
endmodule : opv_vpp_model

// ===== opv_program_unit_sva.sv
`timescale 1ns/1ps
`include "opv_defs.svh"
module opv_program_unit_sva #(
   parameter int WRITE_CYCLES = 20
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic vpp_present,
   input wire logic core_hold,
   input wire logic sys_reset_req,
   input wire logic prog_mode
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire logic wr_dev = reg_wr && reg_addr == `OPV_REG_DEV_CONTROL;
   wire logic wr_mem = reg_wr && reg_addr == `OPV_REG_MEMCTL;
   wire logic wr_dat = reg_wr && reg_addr == `OPV_REG_DATA;
   int cnt_q;
   // Tracks byte cycles only; CRC busy is not modelled here
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) cnt_q <= 0;
      else if (wr_dat && prog_mode && cnt_q == 0) cnt_q <= WRITE_CYCLES;
      else if (cnt_q > 0) cnt_q <= cnt_q - 1;
   end
   sequence s_poll;
      reg_rd && reg_addr == `OPV_REG_STATUS;
   endsequence
   sequence s_crc_go;
      reg_wr && (reg_addr == `OPV_REG_SUM_B0 || reg_addr == `OPV_REG_SUM_B1);
   endsequence
   property p_hold; wr_dev |=> core_hold == $past(reg_wdata[2]); endproperty
   a_hold: assert property (p_hold) else $error("core hold mismatch");
   property p_rst_pulse; wr_dev && reg_wdata[1] |=> sys_reset_req ##1 !sys_reset_req; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse missing");
   property p_rst_cause; sys_reset_req |-> $past(wr_dev && reg_wdata[1]); endproperty
   a_rst_cause: assert property (p_rst_cause) else $error("spurious reset pulse");
   property p_enter; $rose(prog_mode) |-> $past(wr_mem && reg_wdata == `OPV_MEMCTL_STEP2); endproperty
   a_enter: assert property (p_enter) else $error("mode entered without second key");
   property p_keep; prog_mode && !wr_mem |=> prog_mode; endproperty
   a_keep: assert property (p_keep) else $error("mode lost");
   property p_exit; wr_mem && reg_wdata == `OPV_MEMCTL_OFF |=> !prog_mode; endproperty
   a_exit: assert property (p_exit) else $error("mode not left");
   property p_byte_busy; s_poll ##0 (cnt_q > 2) |=> reg_rdata[7]; endproperty
   a_byte_busy: assert property (p_byte_busy) else $error("busy low during byte write");
   property p_crc_busy; s_crc_go ##2 s_poll |=> reg_rdata[7]; endproperty
   a_crc_busy: assert property (p_crc_busy) else $error("busy low during checksum");
endmodule : opv_program_unit_sva

// ===== tb_opv_program_unit.sv
`timescale 1ns/1ps
`include "opv_defs.svh"
module tb_opv_program_unit;
   import opv_pkg::*;
   localparam int WC = 20;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic vpp_apply = 1'b0;
   logic [7:0] reg_rdata;
   logic vpp_present;
   logic core_hold;
   logic sys_reset_req;
   logic prog_mode;
   logic [7:0] mem [0:8191];
   int cur_a = 0;
   int n_fail = 0;
   int tests_run = 0;
   opv_program_unit #(.WRITE_CYCLES(WC)) u_opv_program_unit (.clk_sys(clk_sys), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .vpp_present(vpp_present), .core_hold(core_hold), .sys_reset_req(sys_reset_req), .prog_mode(prog_mode));
   opv_vpp_model u_opv_vpp_model (.apply(vpp_apply), .prog_mode(prog_mode), .vpp_present(vpp_present));
   initial forever #5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask : rchk
   task automatic set_addr(input logic [15:0] a);
      cur_a = a;
      wr(`OPV_REG_ADDRH, a[15:8]);
      wr(`OPV_REG_ADDRL, a[7:0]);
   endtask : set_addr
   task automatic wait_idle(output int n, output logic [7:0] s);
      n = 0;
      s = 8'hff;
      while (s[7] !== 1'b0 && n < 5000) begin
         rd(`OPV_REG_STATUS, s);
         n++;
      end
      // A stuck busy flag counts as a mismatch
      if (n >= 5000) chk(s, 8'h00);
   endtask : wait_idle
   task automatic byte_wr(input logic [7:0] d, input bit ok);
      logic [7:0] s;
      int n;
      wr(`OPV_REG_DATA, d);
      rd(`OPV_REG_STATUS, s);
      chk(s[7], 1'b1);
      wait_idle(n, s);
      chk(n * 2 >= WC - 4, 1'b1);
      chk(n * 2 <= WC + 4, 1'b1);
      chk(s[6], !ok);
      if (ok) mem[cur_a] = mem[cur_a] & d;
      cur_a = cur_a + 1;
   endtask : byte_wr
   function automatic logic [31:0] crc_of(input int base, input int len, input bit wide);
      logic [31:0] c;
      logic [31:0] p;
      c = 32'h00000000;
      p = wide ? `OPV_POLY32 : {`OPV_POLY16, 16'h0000};
      for (int i = 0; i < len; i++) begin
         c = c ^ {mem[base + i], 24'h000000};
         for (int k = 0; k < 8; k++) c = c[31] ? ((c << 1) ^ p) : (c << 1);
      end
      return wide ? c : {16'h0000, c[31:16]};
   endfunction : crc_of
   task automatic crc_chk(input logic [7:0] sel, input logic [7:0] v, input logic [31:0] exp);
      logic [7:0] s;
      int n;
      wr(sel, v);
      rd(`OPV_REG_STATUS, s);
      chk(s[7], 1'b1);
      wait_idle(n, s);
      for (int i = 0; i < 4; i++) rchk(8'(`OPV_REG_SUM_B0 + i), exp[8*i +: 8]);
   endtask : crc_chk
   task automatic mode_on;
      wr(`OPV_REG_DEV_CONTROL, 8'h04);
      #1 chk(core_hold, 1'b1);
      wr(`OPV_REG_MEMCTL, `OPV_MEMCTL_STEP1);
      wr(`OPV_REG_MEMCTL, `OPV_MEMCTL_STEP2);
      #1 chk(prog_mode, 1'b1);
      vpp_apply <= 1'b1;
      // Let the supply filter settle before the first byte
      repeat (10) @(posedge clk_sys);
   endtask : mode_on
   task automatic mode_off;
      wr(`OPV_REG_MEMCTL, `OPV_MEMCTL_STEP1);
      vpp_apply <= 1'b0;
      repeat (10) @(posedge clk_sys);
      wr(`OPV_REG_MEMCTL, `OPV_MEMCTL_OFF);
      #1 chk(prog_mode, 1'b0);
      rchk(`OPV_REG_MEMCTL, `OPV_MEMCTL_OFF);
   endtask : mode_off
   task automatic complete_run;
      $display("Compares %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   initial begin
      #600us;
      n_fail++;
      complete_run();
   end
   initial begin
      foreach (mem[i]) mem[i] = `OPV_ERASED;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      #20us;
      scen_program();
      scen_idle_write();
      scen_checksum();
      scen_stray_key();
      scen_locks();
      scen_finish();
      complete_run();
   end
   task automatic scen_program;
      mode_on();
      set_addr(16'h0100);
      byte_wr(8'ha5, 1'b1);
      byte_wr(8'h3c, 1'b1);
      rchk(`OPV_REG_ADDRH, 8'h01);
      rchk(`OPV_REG_ADDRL, 8'h02);
      set_addr(16'h0101);
      rchk(`OPV_REG_DATA, 8'h3c);
      set_addr(16'h1e00);
      byte_wr(8'h00, 1'b0);
      mode_off();
   endtask : scen_program
   task automatic scen_idle_write;
      set_addr(16'h0100);
      wr(`OPV_REG_DATA, 8'h00);
      // Error from the failed byte stays until the next accepted byte
      rchk(`OPV_REG_STATUS, `OPV_STAT_ERR_MASK);
      rchk(`OPV_REG_ADDRL, 8'h00);
      rchk(`OPV_REG_DATA, 8'ha5);
   endtask : scen_idle_write
   task automatic scen_checksum;
      crc_chk(`OPV_REG_SUM_B1, 8'h00, crc_of(0, 16'h1e00, 1'b1));
      crc_chk(`OPV_REG_SUM_B0, 8'h01, crc_of(256, 256, 1'b0));
   endtask : scen_checksum
   task automatic scen_stray_key;
      wr(`OPV_REG_MEMCTL, `OPV_MEMCTL_STEP1);
      wr(`OPV_REG_MEMCTL, 8'h12);
      wr(`OPV_REG_MEMCTL, `OPV_MEMCTL_STEP2);
      #1 chk(prog_mode, 1'b0);
   endtask : scen_stray_key
   task automatic scen_locks;
      mode_on();
      set_addr(16'h1fff);
      // Both lock fields get a zero, yet the byte reads back distinct from a blocked read
      byte_wr(8'h66, 1'b1);
      set_addr(16'h0102);
      byte_wr(8'h55, 1'b0);
      set_addr(16'h0100);
      rchk(`OPV_REG_DATA, 8'h00);
      set_addr(16'h1fff);
      byte_wr(8'hff, 1'b0);
      set_addr(16'h1fff);
      rchk(`OPV_REG_DATA, 8'h66);
      crc_chk(`OPV_REG_SUM_B0, 8'h01, crc_of(256, 256, 1'b0));
      mode_off();
   endtask : scen_locks
   task automatic scen_finish;
      wr(`OPV_REG_DEV_CONTROL, 8'h02);
      #1 chk(sys_reset_req, 1'b1);
      wr(`OPV_REG_DEV_CONTROL, 8'h00);
      #1 chk(core_hold, 1'b0);
   endtask : scen_finish
endmodule : tb_opv_program_unit
bind opv_program_unit opv_program_unit_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_opv_program_unit_sva (
   .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vpp_present(vpp_present), .core_hold(core_hold),
   .sys_reset_req(sys_reset_req), .prog_mode(prog_mode));
